/* File: mss_pkg.sv */
// constants and state type for the monitor status and result registers
// assumes one clock domain and a word-aligned AHB-Lite register window
package mss_pkg;

    localparam int unsigned NCH = 7;
    localparam int unsigned RES_W = 10;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STAT1 = 8'h00;
    localparam logic [7:0] IDX_STAT2 = 8'h01;
    localparam logic [7:0] IDX_LSB_INT = 8'h03;
    localparam logic [7:0] IDX_LSB_EXT = 8'h04;
    localparam logic [7:0] IDX_VDD_MSB = 8'h06;
    localparam logic [7:0] IDX_INT_MSB = 8'h07;
    localparam logic [7:0] IDX_EXT_MSB = 8'h08;
    localparam logic [7:0] IDX_ANALOG_INPUT_TWO_MSB = 8'h09;
    localparam logic [7:0] IDX_ANALOG_INPUT_THREE_MSB = 8'h0a;
    localparam logic [7:0] IDX_ANALOG_INPUT_FOUR_MSB = 8'h0b;
    localparam logic [7:0] IDX_CTRL = 8'h18;
    localparam logic [7:0] IDX_EVT_STAT = 8'h40;
    localparam logic [7:0] IDX_EVT_CLR = 8'h41;
    localparam logic [7:0] IDX_EVT_EN = 8'h42;

    // conversion channel codes
    localparam logic [2:0] CH_INT = 3'h0;
    localparam logic [2:0] CH_EXT = 3'h1;
    localparam logic [2:0] CH_ANALOG_INPUT_TWO = 3'h2;
    localparam logic [2:0] CH_ANALOG_INPUT_THREE = 3'h3;
    localparam logic [2:0] CH_ANALOG_INPUT_FOUR = 3'h4;
    localparam logic [2:0] CH_VDD = 3'h5;
    localparam logic [2:0] CH_ANALOG_INPUT_ONE = 3'h6;

    // control register fields
    localparam int unsigned CTRL_SEL_LSB = 1;
    localparam int unsigned CTRL_SWRST_BIT = 7;
    localparam logic [1:0] SEL_EXT_SENSOR = 2'h0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // status field positions
    localparam int unsigned ST1_INT_HI = 0;
    localparam int unsigned ST1_INT_LO = 1;
    localparam int unsigned ST1_EXT_HI = 2;
    localparam int unsigned ST1_EXT_LO = 3;
    localparam int unsigned ST1_FAULT = 4;
    localparam int unsigned ST1_ANALOG_INPUT_TWO = 5;
    localparam int unsigned ST1_ANALOG_INPUT_THREE = 6;
    localparam int unsigned ST1_ANALOG_INPUT_FOUR = 7;
    localparam int unsigned ST2_VDD = 4;
    localparam logic [7:0] STAT_RST = 8'h00;

    // interrupt event bits
    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_LIMIT = 0;
    localparam int unsigned EV_RESULT = 1;
    localparam int unsigned EV_FAULT = 2;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;

    typedef struct packed {
        logic [7:0] stat1;
        logic stat2;
        logic [NCH-1:0][RES_W-1:0] res;
        logic [7:0] ctrl;
        logic [EV_W-1:0] evt;
        logic [EV_W-1:0] evt_en;
        logic wr;
        logic [7:0] idx;
        logic [7:0] rdata;
        logic [1:0] fault_sync;
        logic fault_prev;
    } mss_state_t;

endpackage

/* File: mss_cmp_if.sv */
// results, limits and out-of-limit conditions between register file and
// comparator; assumes both ends sit on the same clock
interface mss_cmp_if;
    import mss_pkg::*;

    logic [NCH-1:0][RES_W-1:0] res;
    logic [NCH-1:0][7:0] lim_hi;
    logic [NCH-1:0][7:0] lim_lo;
    logic ext_mode;
    logic fault;
    logic [7:0] cond1;
    logic cond2;

    modport regs (output res, lim_hi, lim_lo, ext_mode, fault,
                  input cond1, cond2);
    modport cmp (input res, lim_hi, lim_lo, ext_mode, fault,
                 output cond1, cond2);
endinterface

/* File: mss_limit_cmp.sv */
// out-of-limit comparators for every conversion channel
// assumes stored results and limits are stable register outputs
module mss_limit_cmp
    import mss_pkg::*;
(
    mss_cmp_if.cmp cif
);

    // upper eight result bits against an eight-bit limit
    function automatic logic over(input logic [RES_W-1:0] v,
                                  input logic [7:0] lim,
                                  input logic sgn);
        if (sgn)
            over = $signed(v[RES_W-1:2]) > $signed(lim);
        else
            over = v[RES_W-1:2] > lim;
    endfunction

    function automatic logic under(input logic [RES_W-1:0] v,
                                   input logic [7:0] lim,
                                   input logic sgn);
        if (sgn)
            under = $signed(v[RES_W-1:2]) <= $signed(lim);
        else
            under = v[RES_W-1:2] <= lim;
    endfunction

    function automatic logic window(input logic [RES_W-1:0] v,
                                    input logic [7:0] hi,
                                    input logic [7:0] lo);
        window = over(v, hi, 1'b0) | under(v, lo, 1'b0);
    endfunction

    always_comb
    begin
        cif.cond1 = 8'h00;
        // temperatures are twos complement
        cif.cond1[ST1_INT_HI] = over(cif.res[CH_INT],
            cif.lim_hi[CH_INT], 1'b1);
        cif.cond1[ST1_INT_LO] = under(cif.res[CH_INT],
            cif.lim_lo[CH_INT], 1'b1);
        if (cif.ext_mode)
        begin
            cif.cond1[ST1_EXT_HI] = over(cif.res[CH_EXT],
                cif.lim_hi[CH_EXT], 1'b1);
            cif.cond1[ST1_EXT_LO] = under(cif.res[CH_EXT],
                cif.lim_lo[CH_EXT], 1'b1);
            cif.cond1[ST1_FAULT] = cif.fault;
        end
        else
        begin
            // first analog input reports its window result in the external high flag bit
            cif.cond1[ST1_EXT_HI] = window(cif.res[CH_ANALOG_INPUT_ONE],
                cif.lim_hi[CH_ANALOG_INPUT_ONE], cif.lim_lo[CH_ANALOG_INPUT_ONE]);
        end
        cif.cond1[ST1_ANALOG_INPUT_TWO] = window(cif.res[CH_ANALOG_INPUT_TWO],
            cif.lim_hi[CH_ANALOG_INPUT_TWO], cif.lim_lo[CH_ANALOG_INPUT_TWO]);
        cif.cond1[ST1_ANALOG_INPUT_THREE] = window(cif.res[CH_ANALOG_INPUT_THREE],
            cif.lim_hi[CH_ANALOG_INPUT_THREE], cif.lim_lo[CH_ANALOG_INPUT_THREE]);
        cif.cond1[ST1_ANALOG_INPUT_FOUR] = window(cif.res[CH_ANALOG_INPUT_FOUR],
            cif.lim_hi[CH_ANALOG_INPUT_FOUR], cif.lim_lo[CH_ANALOG_INPUT_FOUR]);
        cif.cond2 = window(cif.res[CH_VDD],
            cif.lim_hi[CH_VDD], cif.lim_lo[CH_VDD]);
    end

endmodule

/* File: mss_regs.sv */
// status flags and conversion results of the monitor, AHB-Lite slave
// assumes results arrive from a converter on MCLK; fault pin is async
module mss_regs
    import mss_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RESULT_VALID,
    input wire logic [2:0] RESULT_CHAN,
    input wire logic [9:0] RESULT_DATA,
    input wire logic SENSOR_FAULT,
    input wire logic [NCH-1:0][7:0] LIMIT_HIGH,
    input wire logic [NCH-1:0][7:0] LIMIT_LOW,
    output logic IRQ
);

    mss_state_t s_r;
    mss_state_t s_nxt;
    mss_cmp_if cif ();

    logic acc;
    logic rd_acc;
    logic [7:0] acc_idx;
    logic wr_data;
    logic swrst;
    logic [1:0] pin_function_select;
    logic [EV_W-1:0] ev_new;
    logic [EV_W-1:0] ev_clr;
    logic fault_rise;
    logic stat1_clr;
    logic stat2_clr;
    logic [7:0] stat2_upd;

    mss_limit_cmp u_cmp (
        .cif(cif)
    );

    assign pin_function_select = s_r.ctrl[CTRL_SEL_LSB +: 2];
    assign cif.res = s_r.res;
    assign cif.lim_hi = LIMIT_HIGH;
    assign cif.lim_lo = LIMIT_LOW;
    assign cif.ext_mode = (pin_function_select == SEL_EXT_SENSOR);
    // only the second synchroniser stage is looked at
    assign cif.fault = s_r.fault_sync[1];

    // two lowest bits of one stored result
    function automatic logic [1:0] low2(input logic [RES_W-1:0] v);
        low2 = v[1:0];
    endfunction

    // upper eight bits of one stored result
    function automatic logic [7:0] high8(input logic [RES_W-1:0] v);
        high8 = v[RES_W-1:2];
    endfunction

    // one register index decode, shared by read and write strobes
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] b);
        hit = (a == b);
    endfunction

    // sticky flags: a live condition sets the flag again at once
    function automatic logic [7:0] sticky(input logic [7:0] old,
                                          input logic [7:0] cond,
                                          input logic clr);
        sticky = (clr ? STAT_RST : old) | cond;
    endfunction

    // read value of one register index; no side effects here
    function automatic logic [7:0] rd_mux(input logic [7:0] idx,
                                          input mss_state_t s,
                                          input logic ext);
        logic [RES_W-1:0] sel_res;
        sel_res = ext ? s.res[CH_EXT] : s.res[CH_ANALOG_INPUT_ONE];
        rd_mux = 8'h00;
        case (idx)
            IDX_STAT1:
                rd_mux = s.stat1;
            IDX_STAT2:
                rd_mux[ST2_VDD] = s.stat2;
            IDX_LSB_INT:
                rd_mux = {4'h0, low2(s.res[CH_VDD]),
                          low2(s.res[CH_INT])};
            IDX_LSB_EXT:
                rd_mux = {low2(s.res[CH_ANALOG_INPUT_FOUR]), low2(s.res[CH_ANALOG_INPUT_THREE]),
                          low2(s.res[CH_ANALOG_INPUT_TWO]), low2(sel_res)};
            IDX_VDD_MSB:
                rd_mux = high8(s.res[CH_VDD]);
            IDX_INT_MSB:
                rd_mux = high8(s.res[CH_INT]);
            IDX_EXT_MSB:
                rd_mux = high8(sel_res);
            IDX_ANALOG_INPUT_TWO_MSB:
                rd_mux = high8(s.res[CH_ANALOG_INPUT_TWO]);
            IDX_ANALOG_INPUT_THREE_MSB:
                rd_mux = high8(s.res[CH_ANALOG_INPUT_THREE]);
            IDX_ANALOG_INPUT_FOUR_MSB:
                rd_mux = high8(s.res[CH_ANALOG_INPUT_FOUR]);
            IDX_CTRL:
                rd_mux = s.ctrl;
            IDX_EVT_STAT:
                rd_mux = {5'h00, s.evt};
            IDX_EVT_EN:
                rd_mux = {5'h00, s.evt_en};
            default:
                rd_mux = 8'h00;
        endcase
    endfunction

    // zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = {24'h000000, s_r.rdata};
    assign IRQ = |(s_r.evt & s_r.evt_en);

    assign acc = HSEL & HTRANS[1] & HREADY;
    assign rd_acc = acc & ~HWRITE;
    assign acc_idx = HADDR[9:2];
    assign wr_data = s_r.wr;
    // soft reset is a self-clearing write of the control register
    assign swrst = wr_data & hit(s_r.idx, IDX_CTRL) &
                   HWDATA[CTRL_SWRST_BIT];
    // read clear is taken at the accepting edge of the address phase
    assign stat1_clr = swrst | (rd_acc & hit(acc_idx, IDX_STAT1));
    assign stat2_clr = swrst | (rd_acc & hit(acc_idx, IDX_STAT2));
    assign fault_rise = s_r.fault_sync[1] & ~s_r.fault_prev;
    assign ev_clr = (wr_data & hit(s_r.idx, IDX_EVT_CLR)) ?
                    HWDATA[EV_W-1:0] : EV_RST;

    always_comb
    begin
        ev_new = EV_RST;
        ev_new[EV_LIMIT] = |(cif.cond1 & ~s_r.stat1) |
                           (cif.cond2 & ~s_r.stat2);
        ev_new[EV_RESULT] = RESULT_VALID;
        ev_new[EV_FAULT] = fault_rise;
    end

    always_comb
    begin
        s_nxt = s_r;

        // fault pin crosses into MCLK through two flops
        s_nxt.fault_sync = {s_r.fault_sync[0], SENSOR_FAULT};
        s_nxt.fault_prev = s_r.fault_sync[1];

        // address phase; data phase write follows one cycle later
        s_nxt.wr = acc & HWRITE;
        if (acc)
        begin
            s_nxt.idx = acc_idx;
        end

        // read data captured at the address phase so it is ready in
        // the data phase; reading one half never locks the other
        if (rd_acc)
        begin
            s_nxt.rdata = rd_mux(acc_idx, s_r, cif.ext_mode);
        end

        // condition still present keeps the flag: set wins over clear
        s_nxt.stat1 = sticky(s_r.stat1, cif.cond1,
                             stat1_clr);
        stat2_upd = sticky({7'h00, s_r.stat2}, {7'h00, cif.cond2},
                           stat2_clr);
        s_nxt.stat2 = stat2_upd[0];

        // results overwrite in place; reset clears every result, supply
        // included, to zero until the first conversion of that channel
        if (RESULT_VALID && (RESULT_CHAN < 3'(NCH)))
        begin
            s_nxt.res[RESULT_CHAN] = RESULT_DATA;
        end

        if (wr_data)
        begin
            case (s_r.idx)
                IDX_CTRL:
                begin
                    s_nxt.ctrl = HWDATA[7:0];
                    s_nxt.ctrl[CTRL_SWRST_BIT] = 1'b0;
                end
                IDX_EVT_EN:
                    s_nxt.evt_en = HWDATA[EV_W-1:0];
                default:
                    s_nxt.evt_en = s_r.evt_en;
            endcase
        end

        // new events beat a clear in the same cycle
        s_nxt.evt = (s_r.evt & ~ev_clr) | ev_new;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            s_r.stat1 <= STAT_RST;
            s_r.stat2 <= 1'b0;
            s_r.res <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.evt <= EV_RST;
            s_r.evt_en <= EV_RST;
            s_r.wr <= 1'b0;
            s_r.idx <= 8'h00;
            s_r.rdata <= 8'h00;
            s_r.fault_sync <= 2'h0;
            s_r.fault_prev <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

/* File: mss_regs_monitor.sv */
// port checker for the status and result register block
// assumes one clock domain and an async active-high reset
module mss_chk
    import mss_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic RESULT_VALID,
    input wire logic [2:0] RESULT_CHAN,
    input wire logic [9:0] RESULT_DATA
);
    logic [9:0] res_r [0:6];
    logic rd_any;
    logic rd;
    logic [7:0] ix;
    assign rd_any = HSEL & HTRANS[1] & HREADY & !HWRITE;
    // a read beside a new result may legally see either value
    assign rd = rd_any & !RESULT_VALID;
    assign ix = HADDR[9:2];
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < 7; i++)
                res_r[i] <= 10'h000;
        end
        else if (RESULT_VALID && RESULT_CHAN != 3'h7)
        begin
            res_r[RESULT_CHAN] <= RESULT_DATA;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_HIGH_ZERO: assert property (HRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_STAT2_UNUSED: assert property (rd && ix == IDX_STAT2
        |=> (HRDATA[7:0] & 8'hef) == 8'h00) else $error("stat2 spare bit");
    AST_LSB_INT: assert property (rd && ix == IDX_LSB_INT |=>
        HRDATA[7:0] == {4'h0, res_r[CH_VDD][1:0], res_r[CH_INT][1:0]})
        else $error("low bits 0x03 wrong");
    AST_LSB_AIN: assert property (rd && ix == IDX_LSB_EXT |=>
        HRDATA[7:2] == {res_r[CH_ANALOG_INPUT_FOUR][1:0], res_r[CH_ANALOG_INPUT_THREE][1:0],
        res_r[CH_ANALOG_INPUT_TWO][1:0]}) else $error("low bits 0x04 wrong");
    AST_VDD_MSB: assert property (rd && ix == IDX_VDD_MSB |=>
        HRDATA[7:0] == res_r[CH_VDD][9:2]) else $error("supply msb");
    AST_INT_MSB: assert property (rd && ix == IDX_INT_MSB |=>
        HRDATA[7:0] == res_r[CH_INT][9:2]) else $error("int msb");
    AST_ANALOG_INPUT_TWO_MSB: assert property (rd && ix == IDX_ANALOG_INPUT_TWO_MSB |=>
        HRDATA[7:0] == res_r[CH_ANALOG_INPUT_TWO][9:2]) else $error("in2 msb");
    AST_HOLD: assert property (!$stable(HRDATA) |-> $past(rd_any))
        else $error("read data moved without a read");
endmodule

bind mss_regs mss_chk u_chk (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HRDATA(HRDATA), .RESULT_VALID(RESULT_VALID),
    .RESULT_CHAN(RESULT_CHAN), .RESULT_DATA(RESULT_DATA));

/* File: mss_conv_model.sv */
// converter model: hands one result to the register block per call
// assumes it shares MCLK and is called right after a rising edge
module mss_conv_model (
    input wire logic mclk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic valid = 1'b0;
    logic [2:0] chan = 3'h7;
    logic [9:0] data = 10'h000;
    task automatic put(input logic [2:0] ch, input logic [9:0] d);
        valid <= 1'b1;
        chan <= ch;
        data <= d;
        @(posedge mclk);
        valid <= 1'b0;
        data <= ~d; // not held once the pulse ends
        repeat (2) @(posedge mclk);
    endtask
endmodule

/* File: test_monitor_status_result_regs.sv */
// self-checking bench for the status and result register block
// assumes the converter model and the bound port checker
module test_monitor_status_result_regs
    import mss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic fault = 1'b0;
    logic irq;
    logic [NCH-1:0][7:0] lim_hi = {8'hff, {4{8'hf0}}, 8'hff, 8'h40};
    logic [NCH-1:0][7:0] lim_lo = {8'h00, {4{8'h10}}, 8'h00, 8'h80};
    int errors = 0;
    int samples_checked = 0;
    mss_conv_model cnv (.mclk(mclk));
    mss_regs dut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp),
        .RESULT_VALID(cnv.valid), .RESULT_CHAN(cnv.chan),
        .RESULT_DATA(cnv.data), .SENSOR_FAULT(fault),
        .LIMIT_HIGH(lim_hi), .LIMIT_LOW(lim_lo), .IRQ(irq));
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {2'b00, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 8'h00, d);
        chk(d, {24'h0, exp});
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        xfer(1'b1, idx, v, d);
    endtask
    task automatic ci(input logic e);
        @(negedge mclk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge mclk);
    endtask
    // fault pin passes a two-flop sync, so hold it well past that
    task automatic fault_pulse();
        fault <= 1'b1;
        repeat (6) @(posedge mclk);
        fault <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_flags();
        rc(IDX_STAT1, 8'hec);
        rc(IDX_STAT2, 8'h10);
        cnv.put(CH_EXT, 10'h017);
        for (int c = 2; c < 6; c++)
            cnv.put(3'(c), 10'h200);
        rc(IDX_STAT1, 8'hec);
        rc(IDX_STAT1, 8'h04);
        rc(IDX_STAT2, 8'h10);
        rc(IDX_STAT2, 8'h00);
        $display("flags test done");
    endtask
    task automatic t_internal();
        cnv.put(CH_INT, 10'h140);
        rc(IDX_STAT1, 8'h05);
        cnv.put(CH_INT, 10'h200);
        rc(IDX_STAT1, 8'h07);
        cnv.put(CH_INT, 10'h102);
        rc(IDX_STAT1, 8'h06);
        rc(IDX_STAT1, 8'h04);
        $display("internal test done");
    endtask
    task automatic t_fault();
        fault_pulse();
        rc(IDX_STAT1, 8'h14);
        rc(IDX_STAT1, 8'h04);
        fault_pulse();
        wr(IDX_CTRL, 8'h80);
        rc(IDX_STAT1, 8'h04);
        rc(IDX_CTRL, 8'h00);
        $display("fault test done");
    endtask
    task automatic t_low_bits();
        for (int c = 2; c < 5; c++)
            cnv.put(3'(c), 10'h1ff + 10'(c));
        cnv.put(CH_VDD, 10'h3c9);
        cnv.put(CH_ANALOG_INPUT_ONE, 10'h201);
        rc(IDX_LSB_EXT, 8'he7);
        rc(IDX_LSB_INT, 8'h06);
        rc(IDX_VDD_MSB, 8'hf2);
        rc(IDX_INT_MSB, 8'h40);
        rc(IDX_ANALOG_INPUT_TWO_MSB, 8'h80);
        rc(IDX_STAT2, 8'h10);
        rc(8'h02, 8'h00);
        wr(IDX_CTRL, 8'h02);
        rc(IDX_LSB_EXT, 8'he5);
        rc(IDX_EXT_MSB, 8'h80);
        // an upper-half read leaves the lower bits free to follow
        cnv.put(CH_ANALOG_INPUT_TWO, 10'h202);
        rc(IDX_LSB_EXT, 8'he9);
        rc(IDX_STAT1, 8'h04);
        rc(IDX_STAT1, 8'h00);
        cnv.put(CH_ANALOG_INPUT_ONE, 10'h000);
        rc(IDX_STAT1, 8'h04);
        $display("low bits test done");
    endtask
    task automatic t_irq();
        wr(IDX_EVT_CLR, 8'h07);
        wr(IDX_EVT_EN, 8'h02);
        cnv.put(CH_ANALOG_INPUT_THREE, 10'h204);
        ci(1'b1);
        wr(IDX_EVT_EN, 8'h00);
        ci(1'b0);
        wr(IDX_EVT_EN, 8'h02);
        ci(1'b1);
        wr(IDX_EVT_CLR, 8'h02);
        ci(1'b0);
        rc(IDX_EVT_EN, 8'h02);
        wr(IDX_EVT_EN, 8'h07);
        fault_pulse();
        ci(1'b1);
        rc(IDX_EVT_STAT, 8'h04);
        wr(IDX_EVT_CLR, 8'h04);
        ci(1'b0);
        $display("interrupt test done");
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_flags();
        t_internal();
        t_fault();
        t_low_bits();
        t_irq();
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
endmodule
